// *** hw/ksc_pkg.sv ***
// Purpose: constants and types for the keypad scan and sleep cycle block
// Assumes: core_clk at 20 MHz, synchronous active-high reset
// Notes:   pause count is large; the top module takes it as a parameter
package ksc_pkg;

    localparam int          COLS       = 4;
    localparam int          ROWS       = 6;
    localparam int          COL_W      = 2;
    localparam int          ROW_W      = 3;

    localparam logic [3:0]  COL_ALL_LO = 4'h0;
    localparam logic [3:0]  COL_ONE    = 4'h1;
    localparam logic [5:0]  ROW_IDLE   = 6'h3f;
    localparam logic [1:0]  COL_LAST   = 2'h3;
    localparam logic [1:0]  COL_FIRST  = 2'h0;
    localparam logic [2:0]  ROW_RST    = 3'h0;

    localparam longint      CLK_HZ     = 64'h0000_0000_0131_2d00;
    localparam longint      PAUSE_MS   = 64'h0000_0000_0000_017c;
    localparam longint      MS_PER_S   = 64'h0000_0000_0000_03e8;
    localparam longint      PAUSE_CYC  = (PAUSE_MS * CLK_HZ) / MS_PER_S;
    localparam int          CNT_W      = 23;
    localparam logic [22:0] CNT_RST    = 23'h00_0000;
    localparam logic [22:0] CNT_ONE    = 23'h00_0001;

    typedef enum logic [2:0] {
        KSC_IDLE    = 3'b000,
        KSC_DRIVE   = 3'b001,
        KSC_SAMPLE  = 3'b010,
        KSC_RELEASE = 3'b011
    } ksc_state_e;

endpackage

// *** hw/ksc_keypad_sleep.sv ***
// Purpose: keypad interrupt latch, column scan and sleep pause timer
// Assumes: row_sense and shift_held synchronous to core_clk
// Notes:   one settle cycle between column drive and row sample
//
// How it works
// R1 - idle: all four columns driven low
// R2 - key press raises keypad_irq, starts scan
// R3 - scan drives one column low, samples rows
// R4 - no low row: advance to next column
// R5 - key identity is column plus low row
// R6 - shift never interrupts; sampled for second function
// R7 - identified key clears latch by reset pulse
// R8 - measurement done fires trigger, enters power-down
// R9 - after about 380 ms pulse restart
// R10 - empty scan: columns low, clear, report none
`timescale 1ns/1ps
module ksc_keypad_sleep #(
    parameter longint PAUSE_CYCLES = ksc_pkg::PAUSE_CYC
) (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire logic [ksc_pkg::ROWS-1:0]  row_sense,
    input  wire logic                      shift_held,
    input  wire logic                      meas_done,
    output logic      [ksc_pkg::COLS-1:0]  column_drive,
    output logic                           keypad_irq,
    output logic                           latch_clear,
    output logic                           key_valid,
    output logic      [ksc_pkg::COL_W-1:0] key_col,
    output logic      [ksc_pkg::ROW_W-1:0] key_row,
    output logic                           key_second_fn,
    output logic                           no_key,
    output logic                           sleep_timer_trigger,
    output logic                           power_down,
    output logic                           restart_pulse
);
    import ksc_pkg::*;

    localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_CYCLES - 1);

    ksc_state_e        state_ff;
    ksc_state_e        nxt_state;
    logic [COL_W-1:0]  col_ff;
    logic [COL_W-1:0]  nxt_col;
    logic [COLS-1:0]   column_drive_ff;
    logic [COLS-1:0]   nxt_column_drive;
    logic              irq_ff;
    logic              nxt_irq;
    logic              clr_ff;
    logic              nxt_clr;
    logic              valid_ff;
    logic              nxt_valid;
    logic [COL_W-1:0]  kcol_ff;
    logic [COL_W-1:0]  nxt_kcol;
    logic [ROW_W-1:0]  krow_ff;
    logic [ROW_W-1:0]  nxt_krow;
    logic              second_ff;
    logic              nxt_second;
    logic              nokey_ff;
    logic              nxt_nokey;
    logic              row_hit;
    logic [ROW_W-1:0]  row_idx;
    logic              latch_set;
    logic              latch_clr;

    // lowest low row wins when several keys share a column
    always_comb begin
        row_hit = 1'b0;
        row_idx = ROW_RST;
        for (int i = ROWS - 1; i >= 0; i--) begin
            if (!row_sense[i]) begin
                row_hit = 1'b1;
                row_idx = ROW_W'(i);
            end
        end
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_col    = col_ff;
        nxt_kcol   = kcol_ff;
        nxt_krow   = krow_ff;
        nxt_second = second_ff;
        nxt_valid  = 1'b0;
        nxt_nokey  = 1'b0;
        latch_set  = 1'b0;
        latch_clr  = 1'b0;
        case (state_ff)
            KSC_IDLE: begin
                if (row_hit) begin
                    latch_set = 1'b1;                     // see R2
                    nxt_state = KSC_DRIVE;
                    nxt_col   = COL_FIRST;
                end
            end
            // drive cycle lets the matrix lines settle before sampling
            KSC_DRIVE: begin
                nxt_state = KSC_SAMPLE;
            end
            KSC_SAMPLE: begin
                if (row_hit) begin
                    nxt_kcol   = col_ff;                  // see R5
                    nxt_krow   = row_idx;                 // see R5
                    nxt_second = shift_held;              // see R6
                    nxt_valid  = 1'b1;
                    latch_clr  = 1'b1;                    // see R7
                    nxt_state  = KSC_RELEASE;
                end else if (col_ff == COL_LAST) begin
                    nxt_nokey  = 1'b1;                    // see R10
                    latch_clr  = 1'b1;                    // see R10
                    nxt_state  = KSC_RELEASE;
                end else begin
                    nxt_col    = col_ff + COL_W'(1);      // see R4
                    nxt_state  = KSC_DRIVE;
                end
            end
            // wait for release so a held key does not re-interrupt
            KSC_RELEASE: begin
                if (!row_hit) begin
                    nxt_state = KSC_IDLE;
                end
            end
            default: begin
                nxt_state = KSC_IDLE;
            end
        endcase
        nxt_irq = latch_set | (irq_ff & ~latch_clr);
        nxt_clr = latch_clr;
        if (nxt_state == KSC_DRIVE || nxt_state == KSC_SAMPLE) begin
            nxt_column_drive = ~(COL_ONE << nxt_col);     // see R3
        end else begin
            nxt_column_drive = COL_ALL_LO;                // see R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff        <= KSC_IDLE;
            col_ff          <= COL_FIRST;
            column_drive_ff <= COL_ALL_LO;
            irq_ff          <= 1'b0;
            clr_ff          <= 1'b0;
            valid_ff        <= 1'b0;
            kcol_ff         <= COL_FIRST;
            krow_ff         <= ROW_RST;
            second_ff       <= 1'b0;
            nokey_ff        <= 1'b0;
        end else begin
            state_ff        <= nxt_state;
            col_ff          <= nxt_col;
            column_drive_ff <= nxt_column_drive;
            irq_ff          <= nxt_irq;
            clr_ff          <= nxt_clr;
            valid_ff        <= nxt_valid;
            kcol_ff         <= nxt_kcol;
            krow_ff         <= nxt_krow;
            second_ff       <= nxt_second;
            nokey_ff        <= nxt_nokey;
        end
    end

    // sleep cycle
    logic              sleep_ff;
    logic              nxt_sleep;
    logic              trig_ff;
    logic              nxt_trig;
    logic              rst_pulse_ff;
    logic              nxt_rst_pulse;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;

    always_comb begin
        nxt_sleep     = sleep_ff;
        nxt_trig      = 1'b0;
        nxt_rst_pulse = 1'b0;
        nxt_cnt       = cnt_ff;
        if (!sleep_ff) begin
            if (meas_done) begin
                nxt_trig  = 1'b1;                         // see R8
                nxt_sleep = 1'b1;                         // see R8
                nxt_cnt   = CNT_RST;
            end
        end else if (cnt_ff == PAUSE_LAST) begin
            nxt_rst_pulse = 1'b1;                         // see R9
            nxt_sleep     = 1'b0;
            nxt_cnt       = CNT_RST;
        end else begin
            nxt_cnt = cnt_ff + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sleep_ff     <= 1'b0;
            trig_ff      <= 1'b0;
            rst_pulse_ff <= 1'b0;
            cnt_ff       <= CNT_RST;
        end else begin
            sleep_ff     <= nxt_sleep;
            trig_ff      <= nxt_trig;
            rst_pulse_ff <= nxt_rst_pulse;
            cnt_ff       <= nxt_cnt;
        end
    end

    assign column_drive        = column_drive_ff;
    assign keypad_irq          = irq_ff;
    assign latch_clear         = clr_ff;
    assign key_valid           = valid_ff;
    assign key_col             = kcol_ff;
    assign key_row             = krow_ff;
    assign key_second_fn       = second_ff;
    assign no_key              = nokey_ff;
    assign sleep_timer_trigger = trig_ff;
    assign power_down          = sleep_ff;
    assign restart_pulse       = rst_pulse_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_idle_cols_low: assert property ( // see R1
        state_ff == KSC_IDLE |-> column_drive == COL_ALL_LO)
        else $error("columns not all low while idle");
    a_press_irq: assert property ( // see R2
        state_ff == KSC_IDLE && row_sense != ROW_IDLE
        |=> keypad_irq && state_ff == KSC_DRIVE && col_ff == COL_FIRST)
        else $error("press did not raise irq and start scan");
    a_one_col_low: assert property ( // see R3
        state_ff == KSC_DRIVE || state_ff == KSC_SAMPLE
        |-> column_drive == ~(COL_ONE << col_ff))
        else $error("scan column pattern wrong");
    a_next_column: assert property ( // see R4
        state_ff == KSC_SAMPLE && row_sense == ROW_IDLE && col_ff != COL_LAST
        |=> state_ff == KSC_DRIVE && col_ff == $past(col_ff) + COL_W'(1)
            ##1 state_ff == KSC_SAMPLE)
        else $error("scan did not advance column");
    a_key_ident: assert property ( // see R5
        state_ff == KSC_SAMPLE && row_sense != ROW_IDLE
        |=> key_valid && key_col == $past(col_ff) && key_row == $past(row_idx))
        else $error("key identity wrong");
    a_shift_fn: assert property ( // see R6
        key_valid |-> key_second_fn == $past(shift_held))
        else $error("second function not taken from shift");
    a_latch_clear: assert property ( // see R7
        key_valid |-> latch_clear && !keypad_irq)
        else $error("latch not cleared on key");
    a_sleep_start: assert property ( // see R8
        !power_down && meas_done |=> sleep_timer_trigger && power_down)
        else $error("sleep trigger missing");
    a_pause_end: assert property ( // see R9
        power_down && cnt_ff == PAUSE_LAST |=> restart_pulse && !power_down)
        else $error("restart pulse missing at pause end");
    a_pause_len: assert property ( // see R9
        restart_pulse |-> $past(cnt_ff) == PAUSE_LAST)
        else $error("restart before pause elapsed");
    a_empty_scan: assert property ( // see R10
        state_ff == KSC_SAMPLE && row_sense == ROW_IDLE && col_ff == COL_LAST
        |=> no_key && latch_clear && !keypad_irq && column_drive == COL_ALL_LO)
        else $error("empty scan not reported");

    c_key_found: cover property (key_valid);
    c_key_shift: cover property (key_valid && key_second_fn);
    c_no_key:    cover property (no_key);
    c_restart:   cover property (restart_pulse);

endmodule

// *** tb/ksc_key_matrix.sv ***
// Purpose: key matrix of the instrument, seen from the scan logic
// Assumes: rows pulled up, a closed key ties its row to its column
// Notes:   ghost closes only while every column is low (bounce)
`timescale 1ns/1ps
module ksc_key_matrix (
    input  wire logic [3:0] column_drive,
    input  wire logic       press,
    input  wire logic       ghost,
    input  wire logic [1:0] col,
    input  wire logic [2:0] row,
    output logic      [5:0] row_sense
);
    // open rows read the pull-up level, never a held old value
    always_comb begin
        row_sense = 6'h3f;
        if (press && !column_drive[col] &&
            (!ghost || column_drive == 4'h0)) begin
            row_sense[row] = 1'b0;
        end
    end
endmodule

// *** tb/keypad_scan_and_sleep_cycle_bench.sv ***
// Purpose: self-checking bench for keypad scan and sleep pause
// Assumes: pause shortened to 10 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module keypad_scan_and_sleep_cycle_bench;
    import ksc_pkg::*;
    localparam longint PAUSE = 10;
    logic core_clk = 0, sys_rst = 1, shift_held = 0, meas_done = 0;
    logic press = 0, ghost = 0, key_valid, key_second_fn, no_key;
    logic keypad_irq, latch_clear, sleep_timer_trigger;
    logic power_down, restart_pulse;
    logic [1:0] col = 0, key_col;
    logic [2:0] row = 0, key_row;
    logic [5:0] row_sense;
    logic [3:0] column_drive;
    logic [15:0] lfsr = 16'h41ac;
    int errors = 0, checks = 0, n;
    int exp_q[$];

    always #25 core_clk = ~core_clk;

    ksc_key_matrix u_keys (.column_drive(column_drive), .press(press),
        .ghost(ghost), .col(col), .row(row), .row_sense(row_sense));

    ksc_keypad_sleep #(.PAUSE_CYCLES(PAUSE)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .row_sense(row_sense),
        .shift_held(shift_held), .meas_done(meas_done),
        .column_drive(column_drive), .keypad_irq(keypad_irq),
        .latch_clear(latch_clear), .key_valid(key_valid),
        .key_col(key_col), .key_row(key_row),
        .key_second_fn(key_second_fn), .no_key(no_key),
        .sleep_timer_trigger(sleep_timer_trigger),
        .power_down(power_down), .restart_pulse(restart_pulse));

    task automatic step;
        @(posedge core_clk);
        #1;
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one press; ghost makes a key that vanishes once the scan starts
    task automatic press_key(input logic [1:0] c, input logic [2:0] r,
                             input logic s, input logic g);
        logic irq_seen;
        irq_seen = 0;
        col = c; row = r; shift_held = s; ghost = g; press = 1;
        exp_q.push_back(c * 8 + r);
        n = 0;
        step;
        while (key_valid !== 1'b1 && no_key !== 1'b1 && n < 20) begin
            if (keypad_irq === 1'b1) irq_seen = 1;
            check("scan_cols", $countones(column_drive) == 3, 1);
            step;
            n++;
        end
        check("irq_seen", irq_seen, 1);
        check("scan_len", n, g ? 8 : 2 + 2 * c);
        check("key_valid", key_valid, !g);
        check("no_key", no_key, g);
        check("latch_clear", latch_clear, 1);
        check("irq_after", keypad_irq, 0);
        check("cols_after", column_drive, 0);
        n = exp_q.pop_front();
        if (!g) begin
            check("key_id", key_col * 8 + key_row, n);
            check("second_fn", key_second_fn, s);
        end
        press = 0;
        step;
        step;
        check("cols_idle", column_drive, 0);
    endtask

    initial begin
        step;
        step;
        sys_rst = 0;
        check("cols_reset", column_drive, 0);
        shift_held = 1;
        repeat (3) step;
        check("shift_irq", keypad_irq, 0);
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 6; r++) begin
                lfsr = lfsr_next(lfsr);
                press_key(c[1:0], r[2:0], lfsr[0], 0);
            end
        end
        press_key(2'h2, 3'h4, 0, 1);
        // meas_done stays high through the pause: must not re-arm
        meas_done = 1;
        step;
        check("trigger", sleep_timer_trigger, 1);
        check("power_down", power_down, 1);
        n = 0;
        while (restart_pulse !== 1'b1 && n < 100) begin
            step;
            n++;
            check("retrigger", sleep_timer_trigger, 0);
        end
        meas_done = 0;
        check("pause_len", n, PAUSE);
        check("wake", power_down, 0);
        stop_test;
    end

    initial begin
        #100000;
        errors++;
        stop_test;
    end
endmodule
